// ### verilog/cbe_pkg.sv
`default_nettype none
// ==========================================================================
// Shared types and constants of the conditional branch evaluator
package cbe_pkg;

   // ======================================================================
   // Source select encodings
   localparam logic [2:0] CBE_SRC_SINGLE = 3'h0;
   localparam logic [2:0] CBE_SRC_DOUBLE = 3'h1;
   localparam logic [2:0] CBE_SRC_SPECIAL = 3'h5;

   // ======================================================================
   // Special operand encodings, chosen by the register field
   localparam logic [3:0] CBE_SPC_MASK_SPAN = 4'h0;
   localparam logic [3:0] CBE_SPC_MASK_BIT = 4'h1;
   localparam logic [3:0] CBE_SPC_SHORT_STRIP = 4'h2;
   localparam logic [3:0] CBE_SPC_LEN_ZERO = 4'h3;
   localparam logic [3:0] CBE_SPC_COND_CODE = 4'h4;

   // ======================================================================
   // Condition select encodings
   localparam logic [2:0] CBE_CND_ALWAYS = 3'h0;
   localparam logic [2:0] CBE_CND_ALL_ONES = 3'h1;
   localparam logic [2:0] CBE_CND_ALL_ZEROS = 3'h2;
   localparam logic [2:0] CBE_CND_EITHER = 3'h3;
   localparam logic [2:0] CBE_CND_NEG_NZ = 3'h4;
   localparam logic [2:0] CBE_CND_LEFT = 3'h5;
   localparam logic [2:0] CBE_CND_LEFT_ZERO = 3'h6;
   localparam logic [2:0] CBE_CND_RIGHT = 3'h7;

   // ======================================================================
   // Widths and limits
   localparam int CBE_WORD = 36;
   localparam logic [7:0] CBE_MASK_LEN = 8'h40;  // Mask register bits
   localparam logic [7:0] CBE_MAX_INDEX = 8'h3F; // Highest mask index
   localparam int CBE_ZERO_BITS = 2;             // Forced zero target bits

   // ======================================================================
   // Decoded instruction from the issue logic
   typedef struct packed {
      logic is_increment;             // Increment and jump less form
      logic [2:0] src_sel;
      logic [2:0] cond_sel;
      logic invert;
      logic [3:0] first_register_select;
      logic [15:0] offset;
   } cbe_instr_type;

   // Machine state read by the evaluator
   typedef struct packed {
      logic [63:0] mask;              // Bit i is element i
      logic [7:0] element_loop_register; // Element pointer of current loop
      logic [7:0] elem_count;
      logic [7:0] strip_size;
      logic [7:0] mask_test_length;
      logic [1:0] scalar_condition_code;
      logic [35:0] program_counter_register;
   } cbe_state_type;

   // Registered answer to the issue logic
   typedef struct packed {
      logic done;
      logic taken;
      logic len_overflow;
      logic hist_push;
      logic wb_valid;
      logic [35:0] target;
      logic [35:0] wb_data;
   } cbe_result_type;

   localparam cbe_result_type CBE_RESULT_RESET = '0;

endpackage : cbe_pkg
`default_nettype wire

// ### verilog/cbe_conditional_branch_evaluator.sv
`timescale 1ns/10ps
`default_nettype none
module cbe_conditional_branch_evaluator (
   input wire logic i_mclk,
   input wire logic i_nrst,
   input wire logic i_valid,
   input wire cbe_pkg::cbe_instr_type i_instr,
   input wire logic [71:0] i_first_operand,
   input wire logic [35:0] i_second_operand,
   input wire cbe_pkg::cbe_state_type i_state,
   output cbe_pkg::cbe_result_type o_result
);

   // =======================================================================
   // Condition evaluation on an operand summary
   function automatic logic cond_eval(
      input logic [2:0] sel,
      input logic all1,
      input logic all0,
      input logic left,
      input logic right
   );
      logic res;
      res = 1'b0;
      case (sel)
         cbe_pkg::CBE_CND_ALWAYS: res = 1'b1;
         cbe_pkg::CBE_CND_ALL_ONES: res = all1;
         cbe_pkg::CBE_CND_ALL_ZEROS: res = all0;
         cbe_pkg::CBE_CND_EITHER: res = all1 | all0;
         cbe_pkg::CBE_CND_NEG_NZ: res = left & ~all1;
         cbe_pkg::CBE_CND_LEFT: res = left;
         cbe_pkg::CBE_CND_LEFT_ZERO: res = left | all0;
         cbe_pkg::CBE_CND_RIGHT: res = right;
         default: res = 1'b0;
      endcase
      return res;
   endfunction : cond_eval

   // =======================================================================
   // Registered state and its next value
   cbe_pkg::cbe_result_type state;
   cbe_pkg::cbe_result_type next_state;

   // Operand views; bit 35 of a word is the leftmost bit
   logic [35:0] word_hi;
   logic [35:0] word_lo;
   logic [63:0] span_mask;
   logic [5:0] right_idx;
   logic [6:0] nl;
   logic [36:0] raw_sum;
   logic [35:0] inc_sum;
   logic inc_ovf;
   logic [35:0] cmp_a;
   logic [35:0] cmp_b;
   logic less;

   assign word_hi = i_first_operand[71:36];
   assign word_lo = i_first_operand[35:0];
   assign nl = i_state.mask_test_length[6:0];
   assign right_idx = 6'(nl - 7'h01);

   // Bits 0 through length minus one of the mask
   always_comb
   begin
      span_mask = '0;
      for (int i = 0; i < 64; i++)
      begin
         span_mask[i] = (7'(i) < nl);
      end
   end

   // Ones' complement increment with end around carry
   always_comb
   begin
      raw_sum = {1'b0, word_hi} + {1'b0, word_lo};
      inc_sum = raw_sum[35:0] + {35'h0, raw_sum[36]};
      inc_ovf = (word_hi[35] == word_lo[35]) &&
                (inc_sum[35] != word_hi[35]);
   end

   // Signed ones' complement compare with minus zero folded to zero
   always_comb
   begin
      cmp_a = (&inc_sum) ? 36'h0_0000_0000 : inc_sum;
      cmp_b = (&i_second_operand) ? 36'h0_0000_0000
                                  : i_second_operand;
      if (cmp_a[35] != cmp_b[35])
      begin
         less = cmp_a[35];
      end
      else
      begin
         less = (cmp_a < cmp_b);
      end
   end

   // =======================================================================
   // Evaluation of one request
   always_comb
   begin
      logic test;
      logic defined;
      logic ovf;
      logic bitv;
      logic [63:0] m;
      test = 1'b0;
      defined = 1'b1;
      ovf = 1'b0;
      bitv = 1'b0;
      m = i_state.mask;
      next_state = cbe_pkg::CBE_RESULT_RESET;
      next_state.done = i_valid;
      // Segment local target; other segments never produced
      next_state.target = {36{i_valid}} &
                          {i_state.program_counter_register[35:18],
                           {cbe_pkg::CBE_ZERO_BITS{1'b0}},
                           i_instr.offset};
      if (i_instr.is_increment)
      begin
         // Store the sum; overflow stores it truncated, no jump
         next_state.wb_valid = i_valid;
         next_state.wb_data = {36{i_valid}} & inc_sum;
         next_state.taken = i_valid && !inc_ovf && less;
      end
      else
      begin
         // Conditional jump never writes back its operand
         next_state.wb_valid = 1'b0;
         case (i_instr.src_sel)
            cbe_pkg::CBE_SRC_SINGLE:
            begin
               test = cond_eval(i_instr.cond_sel, &word_hi, ~|word_hi,
                                word_hi[35], word_hi[0]);
            end
            cbe_pkg::CBE_SRC_DOUBLE:
            begin
               test = cond_eval(i_instr.cond_sel, &i_first_operand,
                                ~|i_first_operand, i_first_operand[71],
                                i_first_operand[0]);
            end
            cbe_pkg::CBE_SRC_SPECIAL:
            begin
               case (i_instr.first_register_select)
                  cbe_pkg::CBE_SPC_MASK_SPAN:
                  begin
                     if (i_state.mask_test_length > cbe_pkg::CBE_MASK_LEN)
                     begin
                        ovf = 1'b1;
                     end
                     else if (nl == 7'h00)
                     begin
                        test = 1'b1;
                     end
                     else
                     begin
                        test = cond_eval(i_instr.cond_sel,
                                         &(m | ~span_mask),
                                         ~|(m & span_mask), m[0],
                                         m[right_idx]);
                     end
                  end
                  cbe_pkg::CBE_SPC_MASK_BIT:
                  begin
                     if (i_state.element_loop_register >
                         cbe_pkg::CBE_MAX_INDEX)
                     begin
                        ovf = 1'b1;
                     end
                     else
                     begin
                        bitv = m[i_state.element_loop_register[5:0]];
                        test = bitv | cond_eval(i_instr.cond_sel, 1'b0,
                                                1'b1, 1'b0, 1'b0);
                     end
                  end
                  cbe_pkg::CBE_SPC_SHORT_STRIP:
                  begin
                     bitv = (i_state.elem_count < i_state.strip_size);
                     test = bitv | cond_eval(i_instr.cond_sel, 1'b0, 1'b1,
                                             1'b0, 1'b0);
                  end
                  cbe_pkg::CBE_SPC_LEN_ZERO:
                  begin
                     bitv = (i_state.mask_test_length == 8'h00);
                     test = bitv | cond_eval(i_instr.cond_sel, 1'b0, 1'b1,
                                             1'b0, 1'b0);
                  end
                  cbe_pkg::CBE_SPC_COND_CODE:
                  begin
                     // Code mirrors sign state, minus zero coded as zero
                     test = cond_eval(i_instr.cond_sel,
                                  &i_state.scalar_condition_code,
                                  ~|i_state.scalar_condition_code,
                                  i_state.scalar_condition_code[1],
                                  i_state.scalar_condition_code[0]);
                  end
                  default:
                  begin
                     defined = 1'b0;
                  end
               endcase
            end
            default:
            begin
               // Reserved selects define no test and never jump
               defined = 1'b0;
            end
         endcase
         next_state.len_overflow = i_valid && ovf;
         // Inversion, then suppression on overflow or no test
         next_state.taken = i_valid && defined && !ovf &&
                            (test ^ i_instr.invert);
      end
      next_state.hist_push = next_state.taken;
   end

   // =======================================================================
   // State register
   always_ff @(posedge i_mclk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         state <= cbe_pkg::CBE_RESULT_RESET;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign o_result = state;

   // =======================================================================
   // Assertions
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_nrst);

   // Answer follows each request by one cycle
   property p_answer;
      i_valid |=> o_result.done;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer");

   // Target is segment local with offset in low bits
   property p_target;
      i_valid |=> o_result.target ==
         {$past(i_state.program_counter_register[35:18]), 2'b00,
          $past(i_instr.offset)};
   endproperty
   a_target: assert property (p_target) else $error("bad target");

   // Conditional jump never writes a register
   property p_no_write;
      i_valid && !i_instr.is_increment |=> !o_result.wb_valid;
   endproperty
   a_no_write: assert property (p_no_write)
      else $error("jump wrote");

   // Always condition with inversion clear is taken
   property p_always;
      i_valid && !i_instr.is_increment &&
      i_instr.src_sel == cbe_pkg::CBE_SRC_SINGLE &&
      i_instr.cond_sel == cbe_pkg::CBE_CND_ALWAYS
      |=> o_result.taken == !$past(i_instr.invert);
   endproperty
   a_always: assert property (p_always)
      else $error("always test wrong");

   // Reserved source select never jumps
   property p_reserved;
      i_valid && !i_instr.is_increment &&
      i_instr.src_sel != cbe_pkg::CBE_SRC_SINGLE &&
      i_instr.src_sel != cbe_pkg::CBE_SRC_DOUBLE &&
      i_instr.src_sel != cbe_pkg::CBE_SRC_SPECIAL
      |=> o_result.done && !o_result.taken;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved jumped");

   // Mask length above 64 overflows and suppresses
   property p_span_ovf;
      i_valid && !i_instr.is_increment &&
      i_instr.src_sel == cbe_pkg::CBE_SRC_SPECIAL &&
      i_instr.first_register_select == cbe_pkg::CBE_SPC_MASK_SPAN &&
      i_state.mask_test_length > 8'h40
      |=> o_result.len_overflow && !o_result.taken;
   endproperty
   a_span_ovf: assert property (p_span_ovf)
      else $error("span overflow missed");

   // Zero length span is true for every condition
   property p_span_zero;
      i_valid && !i_instr.is_increment && !i_instr.invert &&
      i_instr.src_sel == cbe_pkg::CBE_SRC_SPECIAL &&
      i_instr.first_register_select == cbe_pkg::CBE_SPC_MASK_SPAN &&
      i_state.mask_test_length == 8'h00
      |=> o_result.taken;
   endproperty
   a_span_zero: assert property (p_span_zero)
      else $error("zero span not taken");

   // Element index above 63 overflows
   property p_bit_ovf;
      i_valid && !i_instr.is_increment &&
      i_instr.src_sel == cbe_pkg::CBE_SRC_SPECIAL &&
      i_instr.first_register_select == cbe_pkg::CBE_SPC_MASK_BIT &&
      i_state.element_loop_register > 8'h3F
      |=> o_result.len_overflow && !o_result.taken;
   endproperty
   a_bit_ovf: assert property (p_bit_ovf)
      else $error("index overflow missed");

   // Overflow only on a not taken jump
   property p_ovf_only_cj;
      o_result.len_overflow |-> o_result.done && !o_result.taken &&
         !o_result.wb_valid;
   endproperty
   a_ovf_only_cj: assert property (p_ovf_only_cj)
      else $error("overflow with jump");

   // History entry exactly when taken
   property p_history;
      o_result.hist_push == (o_result.done && o_result.taken);
   endproperty
   a_history: assert property (p_history)
      else $error("history mismatch");

   // Adding plus zero stores the operand unchanged
   property p_inc_store;
      i_valid && i_instr.is_increment &&
      i_first_operand[35:0] == 36'h0_0000_0000
      |=> o_result.wb_valid &&
         o_result.wb_data == $past(i_first_operand[71:36]);
   endproperty
   a_inc_store: assert property (p_inc_store)
      else $error("bad increment store");

   // Overflowed increment falls through
   property p_inc_ovf;
      i_valid && i_instr.is_increment && inc_ovf |=> !o_result.taken;
   endproperty
   a_inc_ovf: assert property (p_inc_ovf)
      else $error("overflow jumped");

   // Main scenarios
   c_taken: cover property (o_result.done && o_result.taken);
   c_ovf: cover property (o_result.len_overflow);
   c_inc_taken: cover property (o_result.wb_valid && o_result.taken);
   c_back_to_back: cover property (o_result.done && i_valid);

endmodule : cbe_conditional_branch_evaluator
`default_nettype wire

// ### verif/cbe_issue_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Issue logic stand-in: presents one decoded request per asked cycle
module cbe_issue_model (
   input wire logic i_mclk,
   input wire logic i_req,
   input wire cbe_pkg::cbe_instr_type i_instr,
   input wire logic [71:0] i_op1,
   input wire logic [35:0] i_op2,
   input wire cbe_pkg::cbe_state_type i_st,
   output logic o_valid,
   output cbe_pkg::cbe_instr_type o_instr,
   output logic [71:0] o_op1,
   output logic [35:0] o_op2,
   output cbe_pkg::cbe_state_type o_st
);
   logic [269:0] last = '0;

   // Remember the last request so idle cycles can show its inverse
   always @(posedge i_mclk)
   begin
      if (i_req)
      begin
         last <= {i_instr, i_op1, i_op2, i_st};
      end
   end

   // Request stands one cycle per ask; idle cycles carry the inverted last request, reserved codes included
   assign o_valid = i_req;
   assign {o_instr, o_op1, o_op2, o_st} =
      i_req ? {i_instr, i_op1, i_op2, i_st} : ~last;
endmodule : cbe_issue_model
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Self-checking bench of the conditional branch evaluator
module tb_top;
   logic i_mclk, i_nrst, req, v;
   cbe_pkg::cbe_instr_type ins, pi;
   cbe_pkg::cbe_state_type st, ps;
   cbe_pkg::cbe_result_type o_result, ex;
   logic [71:0] op1, p1;
   logic [35:0] op2, p2;
   logic [159:0] rr;
   logic [35:0] pl [4];
   logic [35:0] pr [4];
   logic [7:0] nls [8];
   logic [71:0] c1 [4];
   logic [35:0] c2 [4];
   integer seed, failures, checked;

   cbe_issue_model issue (.i_mclk(i_mclk), .i_req(req), .i_instr(ins),
      .i_op1(op1), .i_op2(op2), .i_st(st), .o_valid(v), .o_instr(pi),
      .o_op1(p1), .o_op2(p2), .o_st(ps));
   cbe_conditional_branch_evaluator dut (.i_mclk(i_mclk),
      .i_nrst(i_nrst), .i_valid(v), .i_instr(pi), .i_first_operand(p1),
      .i_second_operand(p2), .i_state(ps), .o_result(o_result));

   // ======================================================================
   // Expectation helpers
   function automatic logic cnd(input logic [2:0] c, input logic a1,
      input logic a0, input logic l, input logic r);
      logic [7:0] t;
      t = {r, l | a0, l, l & ~a1, a1 | a0, a0, a1, 1'b1};
      cnd = t[c];
   endfunction : cnd

   // Ones' complement value with minus zero folded onto zero
   function automatic logic signed [37:0] oc(input logic [35:0] x);
      oc = x[35] ? -$signed({2'b00, ~x}) : $signed({2'b00, x});
   endfunction : oc

   function automatic cbe_pkg::cbe_result_type ev(
      input cbe_pkg::cbe_instr_type in, input logic [71:0] a1,
      input logic [35:0] a2, input cbe_pkg::cbe_state_type s);
      cbe_pkg::cbe_result_type e;
      logic [63:0] m;
      logic [36:0] w;
      logic [35:0] sm;
      logic [1:0] cc;
      logic t, ov, ok, sb, b;
      int nl;
      e = '0;
      e.done = 1'b1;
      e.target = {s.program_counter_register[35:18], 2'b00, in.offset};
      nl = s.mask_test_length;
      m = (nl >= 64) ? '1 : (64'h1 << nl) - 64'h1;
      cc = s.scalar_condition_code;
      {t, ov, sb, b} = '0;
      ok = 1'b1;
      if (in.is_increment)
      begin
         w = {1'b0, a1[71:36]} + {1'b0, a1[35:0]};
         sm = w[35:0] + {35'h0, w[36]};
         e.wb_valid = 1'b1;
         e.wb_data = sm;
         ov = (a1[71] == a1[35]) && (sm[35] != a1[71]);
         e.taken = !ov && (oc(sm) < oc(a2));
      end
      else
      begin
         case (in.src_sel)
            3'h0: t = cnd(in.cond_sel, &a1[71:36], ~|a1[71:36], a1[71],
               a1[36]);
            3'h1: t = cnd(in.cond_sel, &a1, ~|a1, a1[71], a1[0]);
            3'h5:
            case (in.first_register_select)
               4'h0: {ov, t} = {nl > 64, nl == 0 || cnd(in.cond_sel,
                  &(s.mask | ~m), ~|(s.mask & m), s.mask[0],
                  s.mask[(nl - 1) & 63])};
               4'h1: {ov, sb, b} = {s.element_loop_register > 8'h3F, 1'b1,
                  s.mask[s.element_loop_register[5:0]]};
               4'h2: {sb, b} = {1'b1, s.elem_count < s.strip_size};
               4'h3: {sb, b} = {1'b1, nl == 0};
               4'h4: t = cnd(in.cond_sel, &cc, ~|cc, cc[1], cc[0]);
               default: ok = 1'b0;
            endcase
            default: ok = 1'b0;
         endcase
         if (sb)
         begin
            t = b | cnd(in.cond_sel, 1'b0, 1'b1, 1'b0, 1'b0);
         end
         e.len_overflow = ov;
         e.taken = ok & ~ov & (t ^ in.invert);
      end
      e.hist_push = e.taken;
      ev = e;
   endfunction : ev

   // ======================================================================
   // Checking, stepping and closing
   task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
      begin
         $display("NO MISMATCHES");
      end
      else
      begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim

   // Launch a request (or idle), then check its answer after the edge
   task automatic step(input logic r);
      req = r;
      ex = r ? ev(ins, op1, op2, st) : '0;
      @(posedge i_mclk);
      #1;
      chk(o_result.target, ex.target);
      chk(o_result.wb_data, ex.wb_data);
      chk(36'(o_result[76:72]), 36'(ex[76:72]));
   endtask : step

   task automatic rnd(input logic inc);
      rr = {$random(seed), $random(seed), $random(seed), $random(seed),
         $random(seed)};
      st = rr[133:0];
      op1 = rr[159:88];
      rr = {$random(seed), $random(seed), $random(seed), $random(seed),
         $random(seed)};
      ins = rr[27:0];
      op2 = rr[63:28];
      ins.is_increment = inc;
   endtask : rnd

   // ======================================================================
   // Clock and watchdog
   initial
   begin
      i_mclk = 1'b0;
      forever #4 i_mclk = ~i_mclk;
   end

   initial
   begin
      #800000;
      failures++;
      $display("[FAIL] %0t watchdog ran out", $time);
      end_sim();
   end

   // ======================================================================
   // Main sequence
   initial
   begin
      seed = 32'hee16;
      {failures, checked} = '0;
      {req, i_nrst, ins, op1, op2, st, ex} = '0;
      pl = '{36'hF_FFFF_FFFF, 36'h0, 36'h8_0000_0000, 36'h0};
      pr = '{36'hF_FFFF_FFFF, 36'h0, 36'h0, 36'h1};
      nls = '{8'h00, 8'h01, 8'h02, 8'h3F, 8'h40, 8'h41, 8'hC8, 8'h20};
      c1 = '{{36'h7_FFFF_FFFF, 36'h1}, {36'hF_FFFF_FFFF, 36'h0},
         {36'h0, 36'h1}, {36'hF_FFFF_FFFE, 36'h0}};
      c2 = '{36'h0, 36'h0, 36'h2, 36'hF_FFFF_FFFF};
      repeat (10) @(posedge i_mclk);
      #1;
      chk(36'(o_result[76:72]), 36'h0);
      i_nrst = 1'b1;
      // Register sources under every condition, both inversions
      for (int i = 0; i < 128; i++)
      begin
         rnd(1'b0);
         ins.src_sel = {2'b00, i[2]};
         ins.cond_sel = i[6:4];
         ins.invert = i[3];
         op1 = i[2] ? {pl[i[1:0]], pr[i[1:0]]} :
            {pl[i[1:0]] | pr[i[1:0]], op1[35:0]};
         step(1'b1);
      end
      step(1'b0);
      $display("test register sources done");
      // Special operands over length and index corners
      for (int i = 0; i < 192; i++)
      begin
         rnd(1'b0);
         ins.src_sel = cbe_pkg::CBE_SRC_SPECIAL;
         ins.first_register_select = i[3:0];
         st.mask_test_length = nls[i[6:4]];
         st.element_loop_register = nls[i[6:4]];
         if (i[7])
         begin
            st.mask = i[4] ? '1 : '0;
         end
         step(1'b1);
      end
      step(1'b0);
      $display("test special operands done");
      // Reserved source selects answer not taken
      for (int i = 0; i < 40; i++)
      begin
         rnd(1'b0);
         ins.src_sel = 3'(i[0] ? 6 + i[1] : 2 + i % 3);
         step(1'b1);
      end
      step(1'b0);
      $display("test reserved sources done");
      // Increment and jump less, corners first
      for (int i = 0; i < 64; i++)
      begin
         rnd(1'b1);
         if (i < 4)
         begin
            op1 = c1[i];
            op2 = c2[i];
         end
         step(1'b1);
      end
      step(1'b0);
      $display("test increment done");
      // Random mix with random gaps
      for (int i = 0; i < 300; i++)
      begin
         rnd(1'($random(seed)));
         step(1'($random(seed)));
      end
      $display("test random mix done");
      // Reset while an answer is in flight
      step(1'b1);
      i_nrst = 1'b0;
      step(1'b0);
      step(1'b0);
      i_nrst = 1'b1;
      rnd(1'b0);
      step(1'b1);
      step(1'b0);
      $display("test mid reset done");
      end_sim();
   end
endmodule : tb_top
`default_nettype wire
